// >>> design/shp_pkg.sv
package shp_pkg;

    // register map, byte address on the plain register port
    localparam logic [11:0] SHP_ADDR_PORT3_SEL = 12'hf0e;
    localparam logic [11:0] SHP_ADDR_PORT2_SEL = 12'hf0d;
    localparam logic [11:0] SHP_ADDR_CONTROL   = 12'hf0b;
    localparam logic [11:0] SHP_ADDR_PORT2_REF = 12'h002;
    localparam logic [11:0] SHP_ADDR_IRQ_EN    = 12'hffb;

    // field positions and reset values
    localparam int          SHP_CTRL_FLAG_BIT   = 7;
    localparam logic [3:0]  SHP_P3SEL_RESET     = 4'h0;
    localparam logic [7:0]  SHP_P2SEL_RESET     = 8'h00;
    localparam logic [7:0]  SHP_P2REF_RESET     = 8'h00;
    localparam logic [5:0]  SHP_IRQEN_RESET     = 6'h00;
    localparam logic [3:0]  SHP_RSVD_READ       = 4'hf;

    // processor restart address after leaving stop
    localparam logic [15:0] SHP_RESTART_VECTOR  = 16'h000c;

    // opcodes seen from the core
    localparam logic [7:0]  SHP_OP_NOP          = 8'hff;
    localparam logic [7:0]  SHP_OP_STOP         = 8'h6f;

    // oscillator settle time after restart
    localparam int          SHP_CLK_HZ          = 200_000_000;
    localparam int          SHP_OSC_SETTLE_US   = 10;
    localparam int          SHP_OSC_SETTLE_CYC  =
        (SHP_CLK_HZ / 1_000_000) * SHP_OSC_SETTLE_US;
    localparam int          SHP_CNT_W           = 12;

    // power states, one-hot
    typedef enum logic [3:0] {
        SHP_RUN    = 4'h1,
        SHP_HALT   = 4'h2,
        SHP_STOP   = 4'h4,
        SHP_SETTLE = 4'h8
    } shp_state_t;

endpackage : shp_pkg

// >>> design/shp_power_ctrl.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module shp_power_ctrl
    import shp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // ordinary reset causes, one-cycle pulses
    input  wire logic        wdt_timeout,
    input  wire logic        por_event,
    // core instruction issue
    input  wire logic        op_valid,
    input  wire logic [7:0]  op_code,
    input  wire logic        halt_exec,
    input  wire logic        iret_done,
    // interrupt requests, six sources
    input  wire logic [5:0]  irq_req,
    // wake pins
    input  wire logic [7:0]  port2_pins,
    input  wire logic [3:0]  port3_pins,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // clock and reset outputs
    output logic             cpu_clk_en,
    output logic             osc_en,
    output logic             periph_clk_en,
    output logic             core_rst,
    output logic             restart_vec_load,
    output logic      [15:0] restart_vec,
    output logic             irq_take,
    output logic      [2:0]  irq_num,
    output logic             resume_after_halt,
    output logic      [3:0]  power_state
);
    import shp_pkg::*;

    shp_state_t            state_q;
    shp_state_t            state_d;
    logic [SHP_CNT_W-1:0]  settle_q;
    logic [3:0]            p3sel_q;
    logic [7:0]            p2sel_q;
    logic [7:0]            p2ref_q;
    logic [5:0]            irqen_q;
    logic                  flag_q;
    logic                  wake;
    logic                  hard_rst;
    logic                  stop_req;
    logic                  halt_req;
    logic                  nop_seen_q;
    logic [5:0]            irq_live;
    logic                  halt_wake;
    logic                  halt_resume_q;
    logic [2:0]            irq_pick;
    logic                  recover_done;
    logic                  wr_p3sel;
    logic                  wr_p2sel;
    logic                  wr_p2ref;
    logic                  rd_p2ref;
    logic                  wr_ctrl;
    logic                  wr_irqen;

    // watchdog and power-on override every state
    assign hard_rst = wdt_timeout | por_event;

    // register strobe decodes shared by the processes below
    assign wr_p3sel = reg_wr && (reg_addr == SHP_ADDR_PORT3_SEL);
    assign wr_p2sel = reg_wr && (reg_addr == SHP_ADDR_PORT2_SEL);
    assign wr_p2ref = reg_wr && (reg_addr == SHP_ADDR_PORT2_REF);
    assign rd_p2ref = reg_rd && (reg_addr == SHP_ADDR_PORT2_REF);
    assign wr_ctrl  = reg_wr && (reg_addr == SHP_ADDR_CONTROL);
    assign wr_irqen = reg_wr && (reg_addr == SHP_ADDR_IRQ_EN);

    // stop only after a no-op flush
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            nop_seen_q <= 1'b0;
        else if (op_valid)
            nop_seen_q <= (op_code == SHP_OP_NOP);
    end

    // a stop without the flush is ignored: core may be mid-instruction
    assign stop_req = op_valid && (op_code == SHP_OP_STOP) && nop_seen_q;
    assign halt_req = halt_exec && nop_seen_q;

    // recovery pin compare
    // selects and reference come from the registers below
    shp_wake_detect u_wake (
        .clk        (clk),
        .arst_n     (arst_n),
        .port2_pins (port2_pins),
        .port2_ref  (p2ref_q),
        .port2_sel  (p2sel_q),
        .port3_pins (port3_pins),
        .port3_sel  (p3sel_q),
        .wake       (wake)
    );

    assign irq_live  = irq_req & irqen_q;
    assign halt_wake = |irq_live;

    // lowest-numbered enabled request wins
    // fixed priority, so a pile of requests still names one source
    always_comb
    begin
        irq_pick = 3'd0;
        for (int k = 5; k >= 0; k--)
        begin
            if (irq_live[k])
                irq_pick = 3'(k);
        end
    end

    // power state next value
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            SHP_RUN:
            begin
                if (stop_req)
                    state_d = SHP_STOP;
                else if (halt_req)
                    state_d = SHP_HALT;
            end
            SHP_HALT:
            begin
                if (halt_wake)
                    state_d = SHP_RUN;
            end
            SHP_STOP:
            begin
                if (wake)
                    state_d = SHP_SETTLE;
            end
            SHP_SETTLE:
            begin
                if (settle_q == SHP_CNT_W'(SHP_OSC_SETTLE_CYC - 1))
                    state_d = SHP_RUN;
            end
            default:
                state_d = SHP_RUN;
        endcase
        // watchdog or power-on also ends stop
        if (hard_rst)
            state_d = SHP_RUN;
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= SHP_RUN;
        else
            state_q <= state_d;
    end

    // oscillator settle counter, runs only while settling
    // back at zero outside settle, so every recovery waits in full
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            settle_q <= '0;
        else if (state_q == SHP_SETTLE)
            settle_q <= settle_q + 1'b1;
        else
            settle_q <= '0;
    end

    // recovery completes on the settle-to-run step; a watchdog or
    // power-on pulse in that cycle is an ordinary reset instead
    assign recover_done = (state_q == SHP_SETTLE) && (state_d == SHP_RUN)
                          && !hard_rst;

    // halt keeps the oscillator warm: faster wake, more current
    // stop gates core clock and oscillator
    assign cpu_clk_en    = (state_q == SHP_RUN);
    assign osc_en        = (state_q != SHP_STOP);
    // peripherals and interrupts run in halt
    assign periph_clk_en = (state_q != SHP_STOP);
    assign power_state   = state_q;

    // registered so the core reset never glitches on a state change
    // core held in reset until clock stable
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            core_rst         <= 1'b1;
            restart_vec_load <= 1'b0;
            restart_vec      <= SHP_RESTART_VECTOR;
        end
        else
        begin
            core_rst         <= hard_rst || (state_d == SHP_SETTLE)
                                || (state_d == SHP_STOP);
            restart_vec_load <= recover_done;
            restart_vec      <= SHP_RESTART_VECTOR;
        end
    end

    // interrupt handed to core on halt exit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_take <= 1'b0;
            irq_num  <= 3'd0;
        end
        else
        begin
            irq_take <= (state_q == SHP_HALT) && halt_wake && !hard_rst;
            irq_num  <= irq_pick;
        end
    end

    // return lands after the halt opcode
    // pending only until the next return; later returns resume nothing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            halt_resume_q <= 1'b0;
        else if (hard_rst)
            halt_resume_q <= 1'b0;
        else if ((state_q == SHP_HALT) && halt_wake)
            halt_resume_q <= 1'b1;
        else if (iret_done)
            halt_resume_q <= 1'b0;
    end
    assign resume_after_halt = halt_resume_q && iret_done;

    // port 3 selects: cleared by hard reset only
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            p3sel_q <= SHP_P3SEL_RESET;
        else if (hard_rst)
            p3sel_q <= SHP_P3SEL_RESET;
        else if (wr_p3sel)
            p3sel_q <= reg_wdata[3:0];
    end

    // port 2 selects and reference, kept on recovery
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            p2sel_q <= SHP_P2SEL_RESET;
            p2ref_q <= SHP_P2REF_RESET;
        end
        else if (hard_rst)
        begin
            p2sel_q <= SHP_P2SEL_RESET;
            p2ref_q <= SHP_P2REF_RESET;
        end
        else
        begin
            if (wr_p2sel)
                p2sel_q <= reg_wdata;
            // reference from write or last read
            if (wr_p2ref)
                p2ref_q <= reg_wdata;
            else if (rd_p2ref)
                p2ref_q <= port2_pins;
        end
    end

    // interrupt enables, kept through halt
    // cleared by hard reset; a recovery keeps them like the selects
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irqen_q <= SHP_IRQEN_RESET;
        else if (hard_rst)
            irqen_q <= SHP_IRQEN_RESET;
        else if (wr_irqen)
            irqen_q <= reg_wdata[5:0];
    end

    // recovery flag, set wins over write clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            flag_q <= 1'b0;
        else if (hard_rst)
            flag_q <= 1'b0;
        else if (recover_done)
            flag_q <= 1'b1;
        else if (wr_ctrl)
            flag_q <= reg_wdata[SHP_CTRL_FLAG_BIT];
    end

    // read data one cycle after the strobe, zero otherwise
    // zero when idle so a stale byte never looks like a read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            unique case (reg_addr)
                SHP_ADDR_PORT3_SEL: reg_rdata <= {SHP_RSVD_READ, 4'h0};
                SHP_ADDR_PORT2_SEL: reg_rdata <= p2sel_q;
                SHP_ADDR_CONTROL:   reg_rdata <= {flag_q, 7'h00};
                SHP_ADDR_PORT2_REF: reg_rdata <= port2_pins;
                SHP_ADDR_IRQ_EN:    reg_rdata <= {2'h0, irqen_q};
                default:            reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : shp_power_ctrl

// >>> design/shp_wake_detect.sv
`timescale 1ns/1ps

module shp_wake_detect
    import shp_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // pins and selects
    input  wire logic [7:0] port2_pins,
    input  wire logic [7:0] port2_ref,
    input  wire logic [7:0] port2_sel,
    input  wire logic [3:0] port3_pins,
    input  wire logic [3:0] port3_sel,
    // combined wake request, registered
    output logic            wake
);
    logic [11:0] hit;

    // per-pin compare: port 2 against reference, port 3 active low
    genvar i;
    generate
        for (i = 0; i < 12; i++)
        begin : g_pin
            if (i < 8)
            begin : g_p2
                assign hit[i] = port2_sel[i] & (port2_pins[i] ^ port2_ref[i]);
            end
            else
            begin : g_p3
                assign hit[i] = port3_sel[i-8] & ~port3_pins[i-8];
            end
        end
    endgenerate

    // registered so the sequencer sees a clean level
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wake <= 1'b0;
        else
            wake <= |hit;
    end

endmodule : shp_wake_detect

// >>> test/shp_core_model.sv
`timescale 1ns/1ps
module shp_core_model
    import shp_pkg::*;
(
    // clock and return path
    input  wire logic       clk,
    input  wire logic       resume_after_halt,
    // instruction issue
    output logic            op_valid,
    output logic      [7:0] op_code,
    output logic            halt_exec,
    output logic            iret_done
);
    // idle at time zero
    initial
    begin
        op_valid  = 1'b0;
        op_code   = 8'h00;
        halt_exec = 1'b0;
        iret_done = 1'b0;
    end
    // flush before sleep; nop=0 sends another opcode instead
    task automatic sleep(input bit no_operation_instruction, input bit hlt);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= no_operation_instruction ? SHP_OP_NOP : 8'h8f;
        @(posedge clk);
        op_valid  <= !hlt;
        op_code   <= SHP_OP_STOP;
        halt_exec <= hlt;
        @(posedge clk);
        op_valid  <= 1'b0;
        op_code   <= 8'h00;
        halt_exec <= 1'b0;
    endtask : sleep
    // service routine return, resume seen in the same cycle
    task automatic iret(output logic seen);
        @(posedge clk);
        iret_done <= 1'b1;
        #1 seen = resume_after_halt;
        @(posedge clk);
        iret_done <= 1'b0;
    endtask : iret
endmodule : shp_core_model

// >>> test/shp_power_ctrl_checker.sv
`timescale 1ns/1ps
module shp_power_ctrl_checker
    import shp_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // core and reset causes
    input wire logic        wdt_timeout,
    input wire logic        por_event,
    input wire logic        op_valid,
    input wire logic [7:0]  op_code,
    input wire logic        iret_done,
    input wire logic [5:0]  irq_req,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // controller outputs
    input wire logic        cpu_clk_en,
    input wire logic        osc_en,
    input wire logic        periph_clk_en,
    input wire logic        core_rst,
    input wire logic        restart_vec_load,
    input wire logic [15:0] restart_vec,
    input wire logic        resume_after_halt,
    input wire logic [3:0]  power_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // no-op then stop, issued while running
    sequence s_nop;
        op_valid && op_code == SHP_OP_NOP;
    endsequence
    sequence s_stop;
        op_valid && op_code == SHP_OP_STOP && power_state == SHP_RUN
        && !wdt_timeout && !por_event;
    endsequence
    property p_stop_entry;
        s_nop ##1 s_stop |=> power_state == SHP_STOP;
    endproperty
    a_stop_entry: assert property (p_stop_entry)
        else $error("stop not entered after no-op and stop");
    property p_stop_clk;
        power_state == SHP_STOP |-> !cpu_clk_en && !osc_en;
    endproperty
    a_stop_clk: assert property (p_stop_clk)
        else $error("clock or oscillator running in stop");
    property p_stop_exit;
        power_state == SHP_STOP && !wdt_timeout && !por_event
        |=> power_state inside {SHP_STOP, SHP_SETTLE};
    endproperty
    a_stop_exit: assert property (p_stop_exit)
        else $error("stop left without a reset cause");
    property p_halt_clk;
        power_state == SHP_HALT |-> !cpu_clk_en && osc_en && periph_clk_en;
    endproperty
    a_halt_clk: assert property (p_halt_clk)
        else $error("wrong clock gating in halt");
    property p_halt_hold;
        power_state == SHP_HALT && irq_req == 6'h00
        && $past(irq_req) == 6'h00 && !wdt_timeout && !por_event
        |=> power_state == SHP_HALT;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt left with no request");
    property p_settle_rst;
        power_state == SHP_SETTLE |-> core_rst;
    endproperty
    a_settle_rst: assert property (p_settle_rst)
        else $error("core out of reset while settling");
    property p_vec;
        restart_vec_load
        |-> restart_vec == SHP_RESTART_VECTOR && power_state == SHP_RUN;
    endproperty
    a_vec: assert property (p_vec)
        else $error("bad restart address on load");
    property p_resume;
        resume_after_halt |-> iret_done && power_state == SHP_RUN;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume without service return");
    property p_rsvd;
        reg_rd && reg_addr == SHP_ADDR_PORT3_SEL
        |=> reg_rdata[7:4] == SHP_RSVD_READ;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved select bits read wrong");
endmodule : shp_power_ctrl_checker

bind shp_power_ctrl shp_power_ctrl_checker u_shp_power_ctrl_checker (
    .clk(clk), .arst_n(arst_n), .wdt_timeout(wdt_timeout),
    .por_event(por_event), .op_valid(op_valid), .op_code(op_code),
    .iret_done(iret_done), .irq_req(irq_req), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en),
    .osc_en(osc_en), .periph_clk_en(periph_clk_en), .core_rst(core_rst),
    .restart_vec_load(restart_vec_load), .restart_vec(restart_vec),
    .resume_after_halt(resume_after_halt), .power_state(power_state)
);

// >>> test/shp_power_ctrl_test.sv
`timescale 1ns/1ps
module shp_power_ctrl_test;
    import shp_pkg::*;
    logic clk, arst_n, wdt_timeout, por_event, reg_wr, reg_rd;
    logic op_valid, halt_exec, iret_done, cpu_clk_en, osc_en;
    logic periph_clk_en, core_rst, restart_vec_load, irq_take;
    logic resume_after_halt, seen;
    logic [7:0]  op_code, port2_pins, reg_wdata, reg_rdata, rd_q;
    logic [5:0]  irq_req;
    logic [3:0]  port3_pins, power_state;
    logic [11:0] reg_addr;
    logic [15:0] restart_vec;
    logic [2:0]  irq_num;
    int bad_count, n_compared, i;

    shp_power_ctrl u_shp_power_ctrl (.*);
    shp_core_model u_shp_core_model (.*);

    // clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // register bus: one strobe cycle each
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr   <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask : rd

    // bounded wait for a power state
    task automatic wait_st(input logic [3:0] st, input int n);
        for (int k = 0; k < n && power_state !== st; k++)
        begin
            @(posedge clk);
            #1;
        end
        chk(power_state, st);
        if (power_state !== st) stop_test();
    endtask : wait_st

    task automatic go_stop;
        u_shp_core_model.sleep(1'b1, 1'b0);
        wait_st(SHP_STOP, 3);
        chk({cpu_clk_en, osc_en}, 16'h0);
    endtask : go_stop

    // recovery: settle with core held, then restart load
    task automatic wake;
        int k;
        wait_st(SHP_SETTLE, 4);
        chk(core_rst, 1'b1);
        for (k = 0; k < 2100 && restart_vec_load !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        chk(k >= SHP_OSC_SETTLE_CYC - 3 && k <= SHP_OSC_SETTLE_CYC + 3, 1);
        chk(restart_vec, SHP_RESTART_VECTOR);
        chk(core_rst, 1'b0);
        if (k == 2100) stop_test();
    endtask : wake

    task automatic pulse_wdt;
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
    endtask : pulse_wdt

    initial
    begin
        {arst_n, wdt_timeout, por_event, reg_wr, reg_rd} = 5'h0;
        {reg_addr, reg_wdata, irq_req, port2_pins} = 34'h0;
        port3_pins = 4'hf;
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        wait_st(SHP_RUN, 2);
        rd(SHP_ADDR_PORT3_SEL);
        chk(rd_q[7:4], SHP_RSVD_READ);
        rd(12'h100);
        chk(rd_q, 8'h00);
        u_shp_core_model.sleep(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk(power_state, SHP_RUN);
        $display("registers and refusal done");
        wr(SHP_ADDR_IRQ_EN, 8'h3f);
        // each port 3 pin alone; a low unselected pin must not wake
        for (i = 0; i < 4; i++)
        begin
            wr(SHP_ADDR_PORT3_SEL, 8'hf0 | (8'h01 << i));
            go_stop();
            @(posedge clk);
            port3_pins <= ~(4'h1 << ((i + 1) % 4));
            irq_req <= 6'h3f;
            repeat (5) @(posedge clk);
            chk(power_state, SHP_STOP);
            port3_pins <= ~(4'h1 << i);
            irq_req <= 6'h00;
            wake();
            @(posedge clk);
            port3_pins <= 4'hf;
        end
        rd(SHP_ADDR_CONTROL);
        chk(rd_q[SHP_CTRL_FLAG_BIT], 1'b1);
        go_stop();
        @(posedge clk);
        port3_pins <= 4'h7;
        wake();
        @(posedge clk);
        port3_pins <= 4'hf;
        pulse_wdt();
        rd(SHP_ADDR_CONTROL);
        chk(rd_q[SHP_CTRL_FLAG_BIT], 1'b0);
        go_stop();
        @(posedge clk);
        port3_pins <= 4'h7;
        repeat (6) @(posedge clk);
        chk(power_state, SHP_STOP);
        @(posedge clk);
        por_event <= 1'b1;
        @(posedge clk);
        por_event  <= 1'b0;
        port3_pins <= 4'hf;
        wait_st(SHP_RUN, 3);
        $display("stop recovery done");
        wr(SHP_ADDR_PORT2_REF, 8'h00);
        rd(SHP_ADDR_PORT2_REF);
        chk(rd_q, 8'h00);
        wr(SHP_ADDR_PORT2_SEL, 8'h01);
        go_stop();
        @(posedge clk);
        port2_pins <= 8'h01;
        wake();
        wr(SHP_ADDR_PORT2_SEL, 8'h00);
        port2_pins <= 8'h00;
        $display("port 2 wake done");
        // halt per source; a disabled request must not wake
        for (i = 0; i < 6; i++)
        begin
            wr(SHP_ADDR_IRQ_EN, 8'h01 << i);
            u_shp_core_model.sleep(1'b1, 1'b1);
            wait_st(SHP_HALT, 3);
            chk({cpu_clk_en, osc_en, periph_clk_en}, 16'h3);
            @(posedge clk);
            irq_req <= 6'h01 << ((i + 1) % 6);
            repeat (5) @(posedge clk);
            chk(power_state, SHP_HALT);
            irq_req <= 6'h01 << i;
            wait_st(SHP_RUN, 4);
            for (int k = 0; k < 4 && irq_take !== 1'b1; k++)
            begin
                @(posedge clk);
                #1;
            end
            chk(irq_take, 1'b1);
            chk(irq_num, i);
            @(posedge clk);
            irq_req <= 6'h00;
            u_shp_core_model.iret(seen);
            chk(seen, 1'b1);
            u_shp_core_model.iret(seen);
            chk(seen, 1'b0);
        end
        $display("halt wake done");
        stop_test();
    end
endmodule : shp_power_ctrl_test
